/* File: design/ims_sequencer.sv */
// Slave transaction sequencer for a clock block and two memory blocks
`timescale 1ns/1ps
module ims_sequencer #(
	parameter int WR_CYCLES = ims_pkg::WR_CYCLES
) (
	// System clock, reset, enable
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	// Link side
	input wire logic link_clk_i,
	input wire logic ev_valid_i,
	input wire logic [1:0] ev_code_i,
	input wire logic [7:0] ev_byte_i,
	output logic ev_ready_o,
	output logic rsp_valid_o,
	output logic rsp_ack_o,
	output logic [7:0] rsp_byte_o,
	// Status
	output logic busy_o,
	output logic rtc_wr_o
);
	import ims_pkg::*;

	logic req_tgl;
	logic [1:0] req_code;
	logic [7:0] req_byte;
	logic rsp_tgl;
	logic rsp_ack;
	logic [7:0] rsp_byte;
	logic [2:0] req_sync;
	logic req_seen;
	logic take;
	ims_state_e state;
	logic [2:0] blk;
	logic [7:0] ptr;
	logic [7:0] ee_mem [0:EE_BYTES-1];
	logic [7:0] clk_mem [0:CLK_BYTES-1];
	logic [7:0] pbuf [0:PAGE_BYTES-1];
	logic [PAGE_BYTES-1:0] mask;
	logic [4:0] page;
	logic ee_hi;
	logic commit_on;
	logic [2:0] commit_idx;
	logic [31:0] busy_cnt;
	logic clk_dirty;
	logic [2:0] sel;
	logic addr_ok;
	logic sel_ee;
	logic is_start;
	logic is_stop;
	logic is_byte;
	logic is_mack;
	logic wr_ee;
	logic commit_go;

	ims_link_port u_link (
		.link_clk_i(link_clk_i),
		.reset_n_i(reset_n_i),
		.ev_valid_i(ev_valid_i),
		.ev_code_i(ev_code_i),
		.ev_byte_i(ev_byte_i),
		.ev_ready_o(ev_ready_o),
		.rsp_valid_o(rsp_valid_o),
		.rsp_ack_o(rsp_ack_o),
		.rsp_byte_o(rsp_byte_o),
		.req_tgl_o(req_tgl),
		.req_code_o(req_code),
		.req_byte_o(req_byte),
		.rsp_tgl_i(rsp_tgl),
		.rsp_ack_i(rsp_ack),
		.rsp_byte_i(rsp_byte)
	);

	// ------------------------------------------------------------------------
	// Pointer helpers
	// ------------------------------------------------------------------------
	function automatic logic [7:0] next_ptr(input logic [2:0] b, input logic [7:0] p,
			input logic in_page);
		logic [7:0] r;
		r = p + 8'h01;
		if (b == BLK_CLOCK) begin
			r = {4'h0, p[3:0] + 4'h1};
		end else if (in_page) begin
			r = {p[7:3], p[2:0] + 3'h1};
		end
		return r;
	endfunction

	function automatic logic [7:0] read_at(input logic [2:0] b, input logic [7:0] p);
		logic [7:0] r;
		r = clk_mem[p[3:0]];
		if (b != BLK_CLOCK) begin
			r = ee_mem[{b[1], p}];
		end
		return r;
	endfunction

	// ------------------------------------------------------------------------
	// Request crossing
	// ------------------------------------------------------------------------
	// Link fields are held still until answered, so only the toggle is synchronised
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			req_sync <= 3'h0;
			req_seen <= 1'b0;
		end else if (clk_en_i) begin
			req_sync <= {req_sync[1:0], req_tgl};
			if (take) begin
				req_seen <= req_sync[2];
			end
		end
	end

	assign take = clk_en_i && (req_sync[1] == req_sync[2]) && (req_sync[2] != req_seen);
	assign is_start = take && (req_code == EV_START);
	assign is_stop = take && (req_code == EV_STOP);
	assign is_byte = take && (req_code == EV_BYTE);
	assign is_mack = take && (req_code == EV_MACK);
	assign sel = req_byte[BLK_MSB:BLK_LSB];
	assign sel_ee = (sel == BLK_EE_LOW) || (sel == BLK_EE_HIGH);
	assign addr_ok = (req_byte[CODE_MSB:CODE_LSB] == CTRL_CODE)
		&& (sel_ee || (sel == BLK_CLOCK)) && !(sel_ee && busy_o);
	assign wr_ee = is_byte && (state == ST_WDATA) && (blk != BLK_CLOCK);
	assign commit_go = is_stop && (state == ST_WDATA) && (blk != BLK_CLOCK)
		&& (mask != '0);

	// ------------------------------------------------------------------------
	// Transaction sequencing
	// ------------------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= ST_IDLE;
			blk <= BLK_CLOCK;
			ptr <= RESET_PTR;
			rsp_tgl <= 1'b0;
			rsp_ack <= 1'b0;
			rsp_byte <= 8'h00;
		end else if (take) begin
			rsp_tgl <= !rsp_tgl;
			rsp_ack <= 1'b0;
			if (is_start) begin
				state <= ST_ADDR;
			end else if (is_stop) begin
				state <= ST_IDLE;
			end else begin
				case (state)
					ST_ADDR: begin
						if (!addr_ok) begin
							state <= ST_SKIP;
						end else if (req_byte[RW_BIT]) begin
							rsp_ack <= 1'b1;
							blk <= sel;
							state <= ST_RD;
							rsp_byte <= read_at(sel, ptr);
							ptr <= next_ptr(sel, ptr, 1'b0);
						end else begin
							rsp_ack <= 1'b1;
							blk <= sel;
							state <= ST_WORD;
						end
					end
					ST_WORD: begin
						if (is_byte) begin
							rsp_ack <= 1'b1;
							ptr <= (blk == BLK_CLOCK) ? {4'h0, req_byte[3:0]} : req_byte;
							state <= ST_WDATA;
						end
					end
					ST_WDATA: begin
						if (is_byte) begin
							rsp_ack <= 1'b1;
							ptr <= next_ptr(blk, ptr, 1'b1);
						end
					end
					ST_RD: begin
						if (is_mack) begin
							rsp_ack <= 1'b1;
							rsp_byte <= read_at(blk, ptr);
							ptr <= next_ptr(blk, ptr, 1'b0);
						end
					end
					default: begin
						state <= state;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------------
	// Page buffer
	// ------------------------------------------------------------------------
	// The mask is kept through a START during a commit so the running commit is not cut
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mask <= '0;
			page <= 5'h00;
			ee_hi <= 1'b0;
		end else if (clk_en_i) begin
			if (commit_on && (commit_idx == 3'h7)) begin
				mask <= '0;
			end else if (is_start && !commit_on) begin
				mask <= '0;
			end else if (wr_ee) begin
				mask[ptr[2:0]] <= 1'b1;
				page <= ptr[7:3];
				ee_hi <= blk[1];
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (clk_en_i && wr_ee) begin
			pbuf[ptr[2:0]] <= req_byte;
		end
	end

	// ------------------------------------------------------------------------
	// Write cycle
	// ------------------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			busy_cnt <= 32'h0;
		end else if (clk_en_i) begin
			if (commit_go) begin
				busy_cnt <= WR_CYCLES;
			end else if (busy_cnt != 32'h0) begin
				busy_cnt <= busy_cnt - 32'h1;
			end
		end
	end

	assign busy_o = (busy_cnt != 32'h0);

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			commit_on <= 1'b0;
			commit_idx <= 3'h0;
		end else if (clk_en_i) begin
			if (commit_go) begin
				commit_on <= 1'b1;
				commit_idx <= 3'h0;
			end else if (commit_on) begin
				commit_idx <= commit_idx + 3'h1;
				commit_on <= (commit_idx != 3'h7);
			end
		end
	end

	// One byte per cycle so the array keeps a single write port
	always_ff @(posedge sys_clk_i) begin
		if (clk_en_i && commit_on && mask[commit_idx]) begin
			ee_mem[{ee_hi, page, commit_idx}] <= pbuf[commit_idx];
		end
	end

	// ------------------------------------------------------------------------
	// Clock block
	// ------------------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (clk_en_i && is_byte && (state == ST_WDATA) && (blk == BLK_CLOCK)) begin
			clk_mem[ptr[3:0]] <= req_byte;
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			clk_dirty <= 1'b0;
			rtc_wr_o <= 1'b0;
		end else if (clk_en_i) begin
			rtc_wr_o <= is_stop && clk_dirty;
			if (is_start || is_stop) begin
				clk_dirty <= 1'b0;
			end else if (is_byte && (state == ST_WDATA) && (blk == BLK_CLOCK)) begin
				clk_dirty <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	// Snapshot of the byte that a masked commit slot must leave alone
	logic [8:0] keep_addr;
	logic [7:0] keep_byte;

	always_ff @(posedge sys_clk_i) begin
		keep_addr <= {ee_hi, page, commit_idx};
		keep_byte <= ee_mem[{ee_hi, page, commit_idx}];
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_addr_byte;
		is_byte && (state == ST_ADDR) && (req_byte[CODE_MSB:CODE_LSB] == CTRL_CODE);
	endsequence

	sequence s_commit_stop;
		is_stop && (state == ST_WDATA) && (blk != BLK_CLOCK) && (mask != '0);
	endsequence

	a_busy_ee_nack: assert property (s_addr_byte and (sel_ee && busy_o) |=> !rsp_ack)
		else $error("memory access acknowledged while busy");
	a_clock_open: assert property (s_addr_byte and (sel == BLK_CLOCK) |=> rsp_ack)
		else $error("clock block access refused");
	a_poll_done: assert property (s_addr_byte and (sel_ee && !busy_o) |=> rsp_ack)
		else $error("idle memory did not acknowledge");
	a_page_wrap: assert property (wr_ee |=> (ptr[7:3] == $past(ptr[7:3]))
		&& (ptr[2:0] == $past(ptr[2:0]) + 3'h1))
		else $error("page write pointer left its page");
	a_stop_commit: assert property (s_commit_stop |=> busy_o && commit_on ##8 !commit_on)
		else $error("write cycle did not start on stop");
	a_busy_hold: assert property ($rose(busy_o) |-> busy_o [*8])
		else $error("busy dropped early");
	a_word_load: assert property (is_byte && (state == ST_WORD) && (blk != BLK_CLOCK)
		|=> ptr == $past(req_byte))
		else $error("word address not loaded");
	a_read_wrap: assert property (is_mack && (state == ST_RD) && (blk != BLK_CLOCK)
		&& (ptr == 8'hff) |=> ptr == 8'h00)
		else $error("read pointer did not wrap");
	a_clock_wrap: assert property (is_byte && (state == ST_WDATA) && (blk == BLK_CLOCK)
		&& (ptr[3:0] == 4'hf) |=> ptr == 8'h00)
		else $error("clock write pointer did not wrap");
	a_commit_masked: assert property (commit_on && !mask[commit_idx]
		|=> ee_mem[keep_addr] === keep_byte)
		else $error("unsent page byte changed");
	a_answer_each: assert property (take |=> rsp_tgl != $past(rsp_tgl))
		else $error("event left unanswered");

endmodule

/* File: design/ims_pkg.sv */
// Constants and types shared by the memory access sequencer
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package ims_pkg;

	// ------------------------------------------------------------------------
	// Address byte fields
	// ------------------------------------------------------------------------
	localparam logic [3:0] CTRL_CODE = 4'hd;
	localparam int CODE_MSB = 7;
	localparam int CODE_LSB = 4;
	localparam int BLK_MSB = 3;
	localparam int BLK_LSB = 1;
	localparam int RW_BIT = 0;
	localparam logic [2:0] BLK_CLOCK = 3'h0;
	localparam logic [2:0] BLK_EE_LOW = 3'h1;
	localparam logic [2:0] BLK_EE_HIGH = 3'h2;

	// ------------------------------------------------------------------------
	// Memory geometry
	// ------------------------------------------------------------------------
	localparam int PAGE_BYTES = 8;
	localparam int EE_BYTES = 512;
	localparam int CLK_BYTES = 16;
	localparam logic [7:0] RESET_PTR = 8'h00;

	// ------------------------------------------------------------------------
	// Link events and timing
	// ------------------------------------------------------------------------
	localparam logic [1:0] EV_START = 2'h0;
	localparam logic [1:0] EV_STOP = 2'h1;
	localparam logic [1:0] EV_BYTE = 2'h2;
	localparam logic [1:0] EV_MACK = 2'h3;
	localparam int SYS_CLK_MHZ = 100;
	localparam int WR_TIME_US = 100;
	localparam int WR_CYCLES = WR_TIME_US * SYS_CLK_MHZ;

	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_ADDR = 6'b000010,
		ST_WORD = 6'b000100,
		ST_WDATA = 6'b001000,
		ST_RD = 6'b010000,
		ST_SKIP = 6'b100000
	} ims_state_e;

endpackage

/* File: design/ims_link_port.sv */
// Link-clock side of the event handshake toward the sequencer
`timescale 1ns/1ps
module ims_link_port (
	// Link clock and reset
	input wire logic link_clk_i,
	input wire logic reset_n_i,
	// Events from the bit-level receiver
	input wire logic ev_valid_i,
	input wire logic [1:0] ev_code_i,
	input wire logic [7:0] ev_byte_i,
	output logic ev_ready_o,
	// Answers to the bit-level receiver
	output logic rsp_valid_o,
	output logic rsp_ack_o,
	output logic [7:0] rsp_byte_o,
	// Toward the system clock domain
	output logic req_tgl_o,
	output logic [1:0] req_code_o,
	output logic [7:0] req_byte_o,
	input wire logic rsp_tgl_i,
	input wire logic rsp_ack_i,
	input wire logic [7:0] rsp_byte_i
);
	logic pending;
	logic [2:0] rsp_sync;
	logic rsp_seen;
	logic rsp_new;

	// ------------------------------------------------------------------------
	// Request capture
	// ------------------------------------------------------------------------
	// Code and byte stay still while pending, so the far side may sample them
	assign ev_ready_o = !pending;
	assign rsp_new = (rsp_sync[1] == rsp_sync[2]) && (rsp_sync[2] != rsp_seen);

	always_ff @(posedge link_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			req_tgl_o <= 1'b0;
			req_code_o <= 2'h0;
			req_byte_o <= 8'h00;
		end else if (ev_valid_i && !pending) begin
			req_tgl_o <= !req_tgl_o;
			req_code_o <= ev_code_i;
			req_byte_o <= ev_byte_i;
		end
	end

	always_ff @(posedge link_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pending <= 1'b0;
		end else if (ev_valid_i && !pending) begin
			pending <= 1'b1;
		end else if (rsp_new) begin
			pending <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// Answer crossing
	// ------------------------------------------------------------------------
	always_ff @(posedge link_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rsp_sync <= 3'h0;
			rsp_seen <= 1'b0;
			rsp_valid_o <= 1'b0;
			rsp_ack_o <= 1'b0;
			rsp_byte_o <= 8'h00;
		end else begin
			rsp_sync <= {rsp_sync[1:0], rsp_tgl_i};
			rsp_valid_o <= rsp_new;
			if (rsp_new) begin
				rsp_seen <= rsp_sync[2];
				rsp_ack_o <= rsp_ack_i;
				rsp_byte_o <= rsp_byte_i;
			end
		end
	end

endmodule

/* File: tb/ims_master.sv */
// Bus master model that offers link events to the sequencer
`timescale 1ns/1ps
module ims_master (
	// Link clock
	input wire logic link_clk_i,
	// Event request
	output logic ev_valid_o,
	output logic [1:0] ev_code_o,
	output logic [7:0] ev_byte_o,
	input wire logic ev_ready_i,
	// Answer
	input wire logic rsp_valid_i,
	input wire logic rsp_ack_i,
	input wire logic [7:0] rsp_byte_i
);
	logic ack;
	logic [7:0] rdata;
	initial begin
		ev_valid_o = 1'b0;
		ev_code_o = 2'h0;
		ev_byte_o = 8'h00;
	end
	// --------------------------------------------------------------------
	// One event, held until taken, then its answer
	// --------------------------------------------------------------------
	task automatic ev(input logic [1:0] code, input logic [7:0] data);
		int n;
		n = 0;
		@(negedge link_clk_i);
		ev_valid_o = 1'b1;
		ev_code_o = code;
		ev_byte_o = data;
		// Ready only moves on a rising edge, so the falling edge sees what gets sampled
		while (ev_ready_i !== 1'b1 && n < 60) begin
			@(negedge link_clk_i);
			n++;
		end
		@(posedge link_clk_i);
		@(negedge link_clk_i);
		ev_valid_o = 1'b0;
		// Released byte lines show no stale value
		ev_byte_o = ~data;
		while (rsp_valid_i !== 1'b1 && n < 60) begin
			@(negedge link_clk_i);
			n++;
		end
		ack = rsp_ack_i;
		rdata = rsp_byte_i;
		if (n >= 60) begin
			testbench.err_total++;
			testbench.close_out();
		end
	endtask
	task automatic start();
		ev(2'h0, 8'h00);
	endtask
	task automatic stop();
		ev(2'h1, 8'h00);
	endtask
	task automatic put(input logic [7:0] b);
		ev(2'h2, b);
	endtask
	task automatic addr(input logic [2:0] blk, input logic rd);
		ev(2'h2, {4'hd, blk, rd});
	endtask
	// A master acknowledge asks for the next read byte
	task automatic mack();
		ev(2'h3, 8'h00);
	endtask
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the memory access sequencer
`timescale 1ns/1ps
module testbench;
	localparam int WR_CYC = 200;
	logic sys_clk_i, link_clk_i, reset_n_i, clk_en_i;
	logic ev_valid, ev_ready, rsp_valid, rsp_ack, busy, rtc_wr;
	logic [1:0] ev_code;
	logic [7:0] ev_byte, rsp_byte;
	logic [7:0] q[$];
	int err_total = 0;
	int tests_run = 0;
	int rtc_pulses = 0;

	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	// Offset keeps the link clock unrelated in phase to the system clock
	initial begin
		link_clk_i = 1'b0;
		#3;
		forever #40 link_clk_i = ~link_clk_i;
	end
	always @(negedge sys_clk_i) if (rtc_wr === 1'b1) rtc_pulses++;

	ims_sequencer #(.WR_CYCLES(WR_CYC)) ims_sequencer_inst (
		.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
		.link_clk_i(link_clk_i), .ev_valid_i(ev_valid), .ev_code_i(ev_code),
		.ev_byte_i(ev_byte), .ev_ready_o(ev_ready), .rsp_valid_o(rsp_valid),
		.rsp_ack_o(rsp_ack), .rsp_byte_o(rsp_byte), .busy_o(busy), .rtc_wr_o(rtc_wr));
	ims_master m (
		.link_clk_i(link_clk_i), .ev_valid_o(ev_valid), .ev_code_o(ev_code),
		.ev_byte_o(ev_byte), .ev_ready_i(ev_ready), .rsp_valid_i(rsp_valid),
		.rsp_ack_i(rsp_ack), .rsp_byte_i(rsp_byte));

	// --------------------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------------------
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic wr_open(input logic [2:0] blk, input logic [7:0] wa);
		m.start();
		m.addr(blk, 1'b0);
		chk("addr ack", 8'h01, {7'h0, m.ack});
		m.put(wa);
		chk("word ack", 8'h01, {7'h0, m.ack});
	endtask
	task automatic wr_data(input logic [7:0] base, input int n);
		for (int i = 0; i < n; i++) begin
			m.put(base + 8'(i));
			chk("data ack", 8'h01, {7'h0, m.ack});
		end
	endtask
	// Poll until the write cycle is over; the bound catches a stuck busy
	task automatic poll_done(input logic [2:0] blk);
		for (int i = 0; i < 40; i++) begin
			m.start();
			m.addr(blk, 1'b0);
			if (m.ack === 1'b1) break;
			m.stop();
		end
		chk("poll ack", 8'h01, {7'h0, m.ack});
		m.stop();
	endtask
	task automatic rd_seq(input logic [2:0] blk, input logic [7:0] wa);
		wr_open(blk, wa);
		m.start();
		m.addr(blk, 1'b1);
		chk("read addr ack", 8'h01, {7'h0, m.ack});
		foreach (q[i]) begin
			if (i > 0) m.mack();
			chk("read byte", q[i], m.rdata);
		end
		m.stop();
	endtask

	// --------------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------------
	task automatic t_page_and_clock();
		wr_open(3'h1, 8'h00);
		wr_data(8'h10, 10);
		chk("busy before stop", 8'h00, {7'h0, busy});
		m.stop();
		chk("busy after stop", 8'h01, {7'h0, busy});
		m.start();
		m.addr(3'h1, 1'b0);
		chk("busy poll", 8'h00, {7'h0, m.ack});
		m.start();
		m.addr(3'h0, 1'b0);
		chk("clock while busy", 8'h01, {7'h0, m.ack});
		m.put(8'h00);
		wr_data(8'h40, 18);
		m.stop();
		chk("clock write pulse", 8'h01, 8'(rtc_pulses));
		poll_done(3'h1);
		q = {};
		for (int i = 0; i < 8; i++) q.push_back(i < 2 ? 8'h18 + 8'(i) : 8'h10 + 8'(i));
		rd_seq(3'h1, 8'h00);
		q = {};
		for (int i = 0; i < 16; i++) q.push_back(i < 2 ? 8'h50 + 8'(i) : 8'h40 + 8'(i));
		rd_seq(3'h0, 8'h00);
	endtask
	task automatic t_partial_page();
		wr_open(3'h1, 8'h06);
		wr_data(8'ha0, 3);
		m.stop();
		// The cycle counter must stand still while the enable is low
		@(negedge sys_clk_i);
		clk_en_i = 1'b0;
		repeat (300) @(negedge sys_clk_i);
		chk("busy frozen", 8'h01, {7'h0, busy});
		clk_en_i = 1'b1;
		poll_done(3'h1);
		q = {8'ha2, 8'h19, 8'h12, 8'h13, 8'h14, 8'h15, 8'ha0, 8'ha1};
		rd_seq(3'h1, 8'h00);
	endtask
	task automatic t_read_wrap();
		wr_open(3'h2, 8'hfe);
		wr_data(8'hc0, 2);
		m.stop();
		poll_done(3'h2);
		wr_open(3'h2, 8'h00);
		wr_data(8'hc2, 2);
		m.stop();
		poll_done(3'h2);
		q = {8'hc0, 8'hc1};
		rd_seq(3'h2, 8'hfe);
		m.start();
		m.addr(3'h2, 1'b1);
		chk("current address", 8'hc2, m.rdata);
		m.mack();
		chk("read wrap", 8'hc3, m.rdata);
		m.stop();
		q = {8'ha2};
		rd_seq(3'h1, 8'h00);
	endtask
	task automatic t_bad_addr();
		m.start();
		m.put(8'hd6);
		chk("block 011", 8'h00, {7'h0, m.ack});
		m.put(8'h00);
		chk("after nack", 8'h00, {7'h0, m.ack});
		m.start();
		m.put(8'h52);
		chk("wrong code", 8'h00, {7'h0, m.ack});
		m.stop();
	endtask

	initial begin
		reset_n_i = 1'b0;
		clk_en_i = 1'b1;
		repeat (5) @(negedge sys_clk_i);
		reset_n_i = 1'b1;
		chk("idle busy", 8'h00, {7'h0, busy});
		t_page_and_clock();
		t_partial_page();
		t_read_wrap();
		t_bad_addr();
		close_out();
	end
endmodule
